// File: verilog/anp_regs.sv
// Auto-negotiation expansion and next-page register bank
//
// Function
// - Expansion bit 3: partner next-page able
// - Expansion bit 2: local next-page able, resets 1
// - Expansion bit 1: page received, latch high
// - Transmit bit 12 writable acknowledge 2
// - Transmit bit 11 read-only toggle of next word
// - Transmit bits 10..0 writable code, reset 1
// - Partner page register, bit 12 acknowledge 2
// - Partner page bit 11 toggle
// - Partner page low bits hold code field
// - Advertisement bit 15 next-page enable, resets 0
`include "anp_defs.svh"
`default_nettype none
module anp_regs
  import anp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Management access, one-cycle strobes
  input wire anp_mgmt_s mgmt,
  output anp_word_t rdata,
  output logic rvalid,
  // Negotiation engine
  input wire anp_neg_s neg,
  output anp_word_t np_tx_page,
  output logic np_enable
);

  typedef enum logic [1:0] {
    ANP_IDLE = 2'b01,
    ANP_LOADED = 2'b10
  } anp_state_e;

  function automatic logic hit(input anp_mgmt_s m, input logic [4:0] a);
    hit = m.addr == a;
  endfunction

  logic lp_np_reg, lp_an_reg, page_rx_reg, pdf_reg, adv_np_reg;
  logic toggle_reg;
  anp_word_t tx_reg, partner_reg, rdata_next;
  anp_state_e state_reg;
  logic exp_read;

  assign exp_read = mgmt.rd && hit(mgmt, `ANP_OFF_EXPANSION);

  ////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lp_np_reg <= 1'b0;
      lp_an_reg <= 1'b0;
    end else begin
      lp_np_reg <= neg.lp_np_able;
      lp_an_reg <= neg.lp_an_able;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_rx_reg <= 1'b0;
      pdf_reg <= 1'b0;
    end else begin
      page_rx_reg <= neg.page_rx | (page_rx_reg & ~exp_read);
      pdf_reg <= neg.pdf_event | (pdf_reg & ~exp_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= `ANP_RST_NP_TX;
      adv_np_reg <= 1'b0;
    end else begin
      if (mgmt.wr && hit(mgmt, `ANP_OFF_NP_TX)) begin
        tx_reg <= mgmt.wdata;
      end
      if (mgmt.wr && hit(mgmt, `ANP_OFF_ADVERT)) begin
        adv_np_reg <= mgmt.wdata[`ANP_BIT_NEXT_PAGE];
      end
    end
  end

  // Toggle flips each time the engine sends a word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_reg <= 1'b0;
    end else if (neg.tx_taken) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // Tracks whether software has reloaded the page since last send
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ANP_IDLE;
    end else begin
      case (state_reg)
        ANP_IDLE: begin
          if (mgmt.wr && hit(mgmt, `ANP_OFF_NP_TX)) begin
            state_reg <= ANP_LOADED;
          end
        end
        ANP_LOADED: begin
          if (neg.tx_taken) begin
            state_reg <= ANP_IDLE;
          end
        end
        default: state_reg <= ANP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      partner_reg <= `ANP_RST_PARTNER;
    end else if (neg.page_rx) begin
      partner_reg <= neg.page;
      partner_reg[`ANP_BIT_RSVD] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_next = 16'h0000;
    if (hit(mgmt, `ANP_OFF_EXPANSION)) begin
      rdata_next[`ANP_BIT_PDF] = pdf_reg;
      rdata_next[`ANP_BIT_LP_NP_ABLE] = lp_np_reg;
      rdata_next[`ANP_BIT_NP_ABLE] = `ANP_RST_NP_ABLE;
      rdata_next[`ANP_BIT_PAGE_RX] = page_rx_reg;
      rdata_next[`ANP_BIT_LP_AN_ABLE] = lp_an_reg;
    end else if (hit(mgmt, `ANP_OFF_NP_TX)) begin
      rdata_next = tx_reg;
      rdata_next[`ANP_BIT_RSVD] = 1'b0;
      rdata_next[`ANP_BIT_TOGGLE] = toggle_reg;
    end else if (hit(mgmt, `ANP_OFF_PARTNER_NP)) begin
      rdata_next = partner_reg;
    end else if (hit(mgmt, `ANP_OFF_ADVERT)) begin
      rdata_next[`ANP_BIT_NEXT_PAGE] = adv_np_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= mgmt.rd;
      if (mgmt.rd) begin
        rdata <= rdata_next;
      end
    end
  end

  always_comb begin
    np_tx_page = tx_reg;
    np_tx_page[`ANP_BIT_RSVD] = 1'b0;
    np_tx_page[`ANP_BIT_TOGGLE] = toggle_reg;
  end
  assign np_enable = adv_np_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_page_rx_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    neg.page_rx |=> page_rx_reg)
    else $error("page flag not set");
  a_page_rx_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    page_rx_reg && !exp_read |=> page_rx_reg)
    else $error("page flag dropped without a read");
  a_page_rx_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    exp_read && !neg.page_rx |=> !page_rx_reg)
    else $error("page flag not cleared by read");
  a_exp_np_able: assert property (
    @(posedge mclk) disable iff (!rst_n)
    exp_read |=> rdata[`ANP_BIT_NP_ABLE])
    else $error("local next-page bit not one");
  a_exp_reserved: assert property (
    @(posedge mclk) disable iff (!rst_n)
    exp_read |=> rdata[15:5] == 11'h000)
    else $error("reserved expansion bits not zero");
  a_lp_np_follow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> lp_np_reg == $past(neg.lp_np_able))
    else $error("partner np able mismatch");
  a_toggle_flip: assert property (
    @(posedge mclk) disable iff (!rst_n)
    neg.tx_taken |=> toggle_reg != $past(toggle_reg))
    else $error("toggle did not flip");
  a_toggle_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !neg.tx_taken |=> $stable(toggle_reg))
    else $error("toggle moved without a send");
  a_tx_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mgmt.wr && hit(mgmt, `ANP_OFF_NP_TX) |=>
    np_tx_page[12:0] == {$past(mgmt.wdata[12]), toggle_reg,
    $past(mgmt.wdata[10:0])}) else $error("transmit write lost");
  a_tx_loaded: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mgmt.wr && hit(mgmt, `ANP_OFF_NP_TX) |=> state_reg == ANP_LOADED)
    else $error("loaded state not entered");
  a_partner_load: assert property (
    @(posedge mclk) disable iff (!rst_n)
    neg.page_rx |=> partner_reg[12:0] == $past(neg.page[12:0]))
    else $error("partner page not captured");
  a_partner_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !neg.page_rx |=> $stable(partner_reg))
    else $error("partner page changed without an event");
  a_adv_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mgmt.wr && hit(mgmt, `ANP_OFF_ADVERT) |=>
    np_enable == $past(mgmt.wdata[15])) else $error("np enable lost");
  a_read_valid: assert property (
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> rvalid == $past(mgmt.rd))
    else $error("read valid not one cycle after strobe");
  c_page_rx: cover property (@(posedge mclk) disable iff (!rst_n)
    neg.page_rx ##[1:5] exp_read);
  c_tx_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    state_reg == ANP_LOADED ##1 neg.tx_taken);
  c_set_clear: cover property (@(posedge mclk) disable iff (!rst_n)
    exp_read && neg.page_rx);
  c_pdf_set: cover property (@(posedge mclk) disable iff (!rst_n)
    neg.pdf_event ##1 pdf_reg);

endmodule // anp_regs
`default_nettype wire

// File: verilog/anp_defs.svh
// Offsets, field positions, reset values for next-page register bank
`ifndef ANP_DEFS_SVH
`define ANP_DEFS_SVH
`define ANP_OFF_EXPANSION 5'h06
`define ANP_OFF_NP_TX 5'h07
`define ANP_OFF_PARTNER_NP 5'h08
`define ANP_OFF_ADVERT 5'h04
`define ANP_BIT_NEXT_PAGE 15
`define ANP_BIT_RSVD 14
`define ANP_BIT_MSG_PAGE 13
`define ANP_BIT_ACK2 12
`define ANP_BIT_TOGGLE 11
`define ANP_BIT_PDF 4
`define ANP_BIT_LP_NP_ABLE 3
`define ANP_BIT_NP_ABLE 2
`define ANP_BIT_PAGE_RX 1
`define ANP_BIT_LP_AN_ABLE 0
`define ANP_RST_NP_TX 16'h2001
`define ANP_RST_PARTNER 16'h0000
`define ANP_RST_NP_ABLE 1'b1
`endif

// File: verilog/anp_pkg.sv
// Types for the next-page register bank
`default_nettype none
package anp_pkg;
  typedef logic [15:0] anp_word_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anp_mgmt_s;
  typedef struct packed {
    logic lp_np_able;
    logic lp_an_able;
    logic pdf_event;
    logic page_rx;
    logic [15:0] page;
    logic tx_taken;
  } anp_neg_s;
endpackage
`default_nettype wire

// File: tb/anp_sta_model.sv
// Station management model issuing one-cycle register strobes
`default_nettype none
module anp_sta_model
  import anp_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Management bus
  output var anp_mgmt_s mgmt,
  input wire anp_word_t rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mgmt = '0;
  // Read data counts only if rvalid came exactly one cycle after rd
  task automatic acc(input logic w, input logic [4:0] a,
      input anp_word_t d, output anp_word_t q);
    @(posedge mclk) #1;
    mgmt = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge mclk) #1;
    mgmt = '0;
    q = rvalid ? rdata : 'x;
  endtask
endmodule // anp_sta_model
`default_nettype wire

// File: tb/anp_regs_tb.sv
// Self-checking bench for the next-page register bank
`default_nettype none
module anp_regs_tb
  import anp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [4:0] a; anp_word_t d;} anp_row_s;
  logic mclk, rst_n, rvalid, np_enable;
  anp_mgmt_s mgmt;
  anp_neg_s neg;
  anp_word_t rdata, tx_page, q;
  int n_fail, cmp_count, cyc;
  // Writes to read-only places are followed by reads proving no effect
  anp_row_s rows [12] = '{
    '{1'b0, 5'h06, 16'h0004}, '{1'b0, 5'h07, 16'h2001},
    '{1'b0, 5'h08, 16'h0000}, '{1'b0, 5'h1F, 16'h0000},
    '{1'b1, 5'h07, 16'hFFFF}, '{1'b0, 5'h07, 16'hB7FF},
    '{1'b1, 5'h08, 16'h1234}, '{1'b0, 5'h08, 16'h0000},
    '{1'b1, 5'h06, 16'hFFFF}, '{1'b0, 5'h06, 16'h0004},
    '{1'b1, 5'h04, 16'h8000}, '{1'b0, 5'h04, 16'h8000}};
  anp_regs dut_u (.mclk(mclk), .rst_n(rst_n), .mgmt(mgmt), .rdata(rdata),
    .rvalid(rvalid), .neg(neg), .np_tx_page(tx_page),
    .np_enable(np_enable));
  anp_sta_model sta_u (.mclk(mclk), .mgmt(mgmt), .rdata(rdata),
    .rvalid(rvalid));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input anp_word_t seen, input anp_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    neg = '0;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(tx_page, 16'h2001);
    foreach (rows[i]) begin
      sta_u.acc(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) chk(q, rows[i].d);
    end
    chk(anp_word_t'(np_enable), 16'h0001);
    $display("table done");
    neg.lp_np_able = 1'b1;
    neg.lp_an_able = 1'b1;
    neg.page = 16'hFFFF;
    neg.page_rx = 1'b1;
    neg.tx_taken = 1'b1;
    @(posedge mclk) #1;
    neg.page_rx = 1'b0;
    neg.tx_taken = 1'b0;
    chk(tx_page, 16'hBFFF);
    sta_u.acc(1'b0, 5'h08, 16'h0000, q);
    chk(q, 16'hBFFF);
    sta_u.acc(1'b0, 5'h06, 16'h0000, q);
    chk(q, 16'h000F);
    sta_u.acc(1'b0, 5'h06, 16'h0000, q);
    chk(q, 16'h000D);
    $display("page events done");
    // Events in the cycle of the clearing read: the set must win
    fork
      sta_u.acc(1'b0, 5'h06, 16'h0000, q);
      begin
        @(posedge mclk) #1;
        neg.page_rx = 1'b1;
        neg.pdf_event = 1'b1;
        neg.tx_taken = 1'b1;
        @(posedge mclk) #1;
        neg.page_rx = 1'b0;
        neg.pdf_event = 1'b0;
        neg.tx_taken = 1'b0;
      end
    join
    chk(q, 16'h000D);
    chk(tx_page, 16'hB7FF);
    sta_u.acc(1'b0, 5'h06, 16'h0000, q);
    chk(q, 16'h001F);
    $display("set against clear done");
    neg = '0;
    rst_n = 1'b0;
    #1;
    chk(tx_page, 16'h2001);
    chk(anp_word_t'(np_enable), 16'h0000);
    @(posedge mclk) #1 rst_n = 1'b1;
    sta_u.acc(1'b0, 5'h08, 16'h0000, q);
    chk(q, 16'h0000);
    $display("reset done");
    report_and_stop();
  end
endmodule // anp_regs_tb
`default_nettype wire
